// ---- src/mif_pkg.sv ----
// ============================================================
// Shared constants for the mailbox interrupt flag block.
// ============================================================
package mif_pkg;

    // Number of host-writable mailboxes served by the block.
    localparam int unsigned MIF_NUM_MBOX    = 4;

    // Width of the control/status image and of the clear word.
    localparam int unsigned MIF_IMG_W       = 8;

    // Bit positions of the pending flags in the status image.
    localparam int unsigned MIF_PEND0_POS   = 0;
    localparam int unsigned MIF_PEND1_POS   = 1;
    localparam int unsigned MIF_PEND2_POS   = 2;
    localparam int unsigned MIF_PEND3_POS   = 3;

    // Bit positions of the enable bits in the control image.
    localparam int unsigned MIF_EN0_POS     = 4;
    localparam int unsigned MIF_EN1_POS     = 5;
    localparam int unsigned MIF_EN2_POS     = 6;
    localparam int unsigned MIF_EN3_POS     = 7;

    // Bit positions of the overrun flags in the clear word.
    localparam int unsigned MIF_OVR_LSB     = 4;

    // Values after reset.
    localparam logic [3:0]  MIF_EN_RST      = 4'h0;
    localparam logic        MIF_PEND_RST    = 1'b0;
    localparam logic        MIF_OVR_RST     = 1'b0;
    localparam logic [7:0]  MIF_IMG_RST     = 8'h00;

    // Default width of the per-mailbox accepted-write counters.
    localparam int unsigned MIF_CNT_W       = 8;

endpackage : mif_pkg

// ---- src/mif_flag.sv ----
`timescale 1ns/10ps
// ============================================================
// One pending flag with its overrun flag, for a single mailbox.
// ============================================================
module mif_flag
    import mif_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Event and control.
    input  wire logic host_wr,
    input  wire logic enable,
    input  wire logic clr_pend,
    input  wire logic clr_ovr,
    // Flag state.
    output logic      pend_nxt,
    output logic      pending,
    output logic      overrun
);

    logic set_evt;
    logic ovr_nxt;
    logic pend_r;
    logic ovr_r;

    // A host write only counts while the enable bit is one.
    assign set_evt = host_wr & enable;

    // Next values; the set wins over a clear in the same cycle.
    always_comb begin
        pend_nxt = pend_r;
        ovr_nxt  = ovr_r;
        if (set_evt) begin
            pend_nxt = 1'b1;
        end else if (clr_pend) begin
            pend_nxt = 1'b0;
        end
        // A second write while still pending loses an event.
        if (set_evt && pend_r && !clr_pend) begin
            ovr_nxt = 1'b1;
        end else if (clr_ovr) begin
            ovr_nxt = 1'b0;
        end
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_r <= MIF_PEND_RST;
            ovr_r  <= MIF_OVR_RST;
        end else begin
            pend_r <= pend_nxt;
            ovr_r  <= ovr_nxt;
        end
    end

    assign pending = pend_r;
    assign overrun = ovr_r;

endmodule // mif_flag

// ---- src/mif_top.sv ----
`timescale 1ns/10ps
// ============================================================
// Mailbox interrupt enable and pending flags, local side.
// ============================================================
module mif_top
    import mif_pkg::*;
#(
    parameter int unsigned CNT_W = MIF_CNT_W
)
(
    // Clock and reset.
    input  wire logic                 MCLK,
    input  wire logic                 RST_N,
    // Control word written by the local processor.
    input  wire logic                 CTRL_WR,
    input  wire logic [MIF_IMG_W-1:0] CTRL_WDATA,
    // Write-one-to-clear word for pending and overrun flags.
    input  wire logic                 STAT_CLR,
    input  wire logic [MIF_IMG_W-1:0] STAT_CLR_DATA,
    // Host write strobes, one per mailbox.
    input  wire logic [3:0]           HOST_MBOX_WR,
    // Accepted-write counter access.
    input  wire logic                 CNT_CLR,
    input  wire logic [1:0]           CNT_SEL,
    // Enable bits.
    output logic                      MBOX0_IRQ_ENABLE,
    output logic                      MBOX1_IRQ_ENABLE,
    output logic                      MBOX2_IRQ_ENABLE,
    output logic                      MBOX3_IRQ_ENABLE,
    // Pending flags.
    output logic                      MBOX0_IRQ_PENDING,
    output logic                      MBOX1_IRQ_PENDING,
    output logic                      MBOX2_IRQ_PENDING,
    output logic                      MBOX3_IRQ_PENDING,
    // Status and control images, overruns and counters.
    output logic [MIF_IMG_W-1:0]      CTRL_STATUS,
    output logic [3:0]                OVERRUN,
    output logic [CNT_W-1:0]          CNT_VALUE,
    // Local interrupt request.
    output logic                      IRQ
);

    // ========================================================
    // Local signals.
    // ========================================================
    logic [3:0]           en_r;
    logic [3:0]           en_nxt;
    logic [3:0]           clr_pend;
    logic [3:0]           clr_ovr;
    logic [3:0]           pend_nxt;
    logic [3:0]           pend;
    logic [3:0]           ovr;
    logic [3:0]           accepted;
    logic [MIF_IMG_W-1:0] img_r;
    logic [MIF_IMG_W-1:0] img_nxt;
    logic                 irq_r;
    logic                 irq_nxt;
    logic [CNT_W-1:0]     cnt_r   [MIF_NUM_MBOX];
    logic [CNT_W-1:0]     cnt_nxt [MIF_NUM_MBOX];
    logic [CNT_W-1:0]     cnt_out_r;
    logic [CNT_W-1:0]     cnt_out_nxt;

    // Saturating increment, used by every mailbox counter.
    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] v
    );
        logic [CNT_W-1:0] r;
        r = v;
        if (v != {CNT_W{1'b1}}) begin
            r = v + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        return r;
    endfunction

    // ========================================================
    // Enable bits.
    // ========================================================
    // Each enable sits at its own position in the control word.
    // A write replaces all four bits at once.
    always_comb begin
        en_nxt = en_r;
        if (CTRL_WR) begin
            en_nxt[0] = CTRL_WDATA[MIF_EN0_POS];
            en_nxt[1] = CTRL_WDATA[MIF_EN1_POS];
            en_nxt[2] = CTRL_WDATA[MIF_EN2_POS];
            en_nxt[3] = CTRL_WDATA[MIF_EN3_POS];
        end
    end

    // Enable register; all interrupts start disabled.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            en_r <= MIF_EN_RST;
        end else begin
            en_r <= en_nxt;
        end
    end

    // ========================================================
    // Clear decode.
    // ========================================================
    // Only ones in the clear word act; zeros leave flags alone.
    always_comb begin
        clr_pend = 4'h0;
        clr_ovr  = 4'h0;
        if (STAT_CLR) begin
            clr_pend[0] = STAT_CLR_DATA[MIF_PEND0_POS];
            clr_pend[1] = STAT_CLR_DATA[MIF_PEND1_POS];
            clr_pend[2] = STAT_CLR_DATA[MIF_PEND2_POS];
            clr_pend[3] = STAT_CLR_DATA[MIF_PEND3_POS];
            clr_ovr     = STAT_CLR_DATA[MIF_OVR_LSB +: 4];
        end
    end

    // ========================================================
    // Pending flags.
    // ========================================================
    // The enable in force when the host write lands decides.
    // Writing a new enable in the same cycle takes effect only
    // for later host writes, which keeps the gate glitch free.
    for (genvar i = 0; i < MIF_NUM_MBOX; i++) begin : g_flag
        mif_flag u_flag (
            .clk      (MCLK),
            .rst_n    (RST_N),
            .host_wr  (HOST_MBOX_WR[i]),
            .enable   (en_r[i]),
            .clr_pend (clr_pend[i]),
            .clr_ovr  (clr_ovr[i]),
            .pend_nxt (pend_nxt[i]),
            .pending  (pend[i]),
            .overrun  (ovr[i])
        );
    end

    // Host writes that were accepted into a pending flag.
    assign accepted = HOST_MBOX_WR & en_r;

    // ========================================================
    // Status image and interrupt.
    // ========================================================
    // The image is built from next values, so it lines up with
    // the flag and enable outputs in the same cycle.
    always_comb begin
        img_nxt                = MIF_IMG_RST;
        img_nxt[MIF_PEND0_POS] = pend_nxt[0];
        img_nxt[MIF_PEND1_POS] = pend_nxt[1];
        img_nxt[MIF_PEND2_POS] = pend_nxt[2];
        img_nxt[MIF_PEND3_POS] = pend_nxt[3];
        img_nxt[MIF_EN0_POS]   = en_nxt[0];
        img_nxt[MIF_EN1_POS]   = en_nxt[1];
        img_nxt[MIF_EN2_POS]   = en_nxt[2];
        img_nxt[MIF_EN3_POS]   = en_nxt[3];
    end

    // A pending flag whose enable is later dropped stops the
    // request but stays pending until software clears it.
    assign irq_nxt = |(pend_nxt & en_nxt);

    // Image and interrupt registers.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            img_r <= MIF_IMG_RST;
            irq_r <= 1'b0;
        end else begin
            img_r <= img_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ========================================================
    // Accepted-write counters.
    // ========================================================
    // Counters saturate rather than wrap, so a stuck host shows
    // as a full count instead of a small misleading one. A host
    // write in the clearing cycle still counts as one.
    always_comb begin
        for (int i = 0; i < MIF_NUM_MBOX; i++) begin
            cnt_nxt[i] = cnt_r[i];
            if (CNT_CLR) begin
                cnt_nxt[i] = {CNT_W{1'b0}};
            end
            if (accepted[i]) begin
                cnt_nxt[i] = sat_inc(cnt_nxt[i]);
            end
        end
        cnt_out_nxt = cnt_nxt[CNT_SEL];
    end

    // Counter registers.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            for (int i = 0; i < MIF_NUM_MBOX; i++) begin
                cnt_r[i] <= {CNT_W{1'b0}};
            end
            cnt_out_r <= {CNT_W{1'b0}};
        end else begin
            for (int i = 0; i < MIF_NUM_MBOX; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
            cnt_out_r <= cnt_out_nxt;
        end
    end

    // ========================================================
    // Outputs, all taken from flip-flops.
    // ========================================================
    assign MBOX0_IRQ_ENABLE  = en_r[0];
    assign MBOX1_IRQ_ENABLE  = en_r[1];
    assign MBOX2_IRQ_ENABLE  = en_r[2];
    assign MBOX3_IRQ_ENABLE  = en_r[3];
    assign MBOX0_IRQ_PENDING = pend[0];
    assign MBOX1_IRQ_PENDING = pend[1];
    assign MBOX2_IRQ_PENDING = pend[2];
    assign MBOX3_IRQ_PENDING = pend[3];
    assign CTRL_STATUS       = img_r;
    assign OVERRUN           = ovr;
    assign CNT_VALUE         = cnt_out_r;
    assign IRQ               = irq_r;

endmodule // mif_top

// ---- testbench/mif_properties.sv ----
`timescale 1ns/10ps
// ============================================================
// Checker for the mailbox interrupt flags.
// ============================================================
module mif_properties
    import mif_pkg::*;
(
    // Clock and reset.
    input wire logic                 MCLK,
    input wire logic                 RST_N,
    // Requests.
    input wire logic                 CTRL_WR,
    input wire logic [MIF_IMG_W-1:0] CTRL_WDATA,
    input wire logic                 STAT_CLR,
    input wire logic [MIF_IMG_W-1:0] STAT_CLR_DATA,
    input wire logic [3:0]           HOST_MBOX_WR,
    // Flags.
    input wire logic                 MBOX0_IRQ_ENABLE,
    input wire logic                 MBOX1_IRQ_ENABLE,
    input wire logic                 MBOX2_IRQ_ENABLE,
    input wire logic                 MBOX3_IRQ_ENABLE,
    input wire logic                 MBOX0_IRQ_PENDING,
    input wire logic                 MBOX1_IRQ_PENDING,
    input wire logic                 MBOX2_IRQ_PENDING,
    input wire logic                 MBOX3_IRQ_PENDING,
    input wire logic [MIF_IMG_W-1:0] CTRL_STATUS,
    input wire logic                 IRQ
);
    // All checks share the one clock; all but p_rst are also disabled by the one reset.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    property p_set0; MBOX0_IRQ_ENABLE && HOST_MBOX_WR[0] |=> MBOX0_IRQ_PENDING;
    endproperty
    a_set0: assert property (p_set0) else $error("mbox0 not set");
    property p_set1; MBOX1_IRQ_ENABLE && HOST_MBOX_WR[1] |=> MBOX1_IRQ_PENDING;
    endproperty
    a_set1: assert property (p_set1) else $error("mbox1 not set");
    property p_set2; MBOX2_IRQ_ENABLE && HOST_MBOX_WR[2] |=> MBOX2_IRQ_PENDING;
    endproperty
    a_set2: assert property (p_set2) else $error("mbox2 not set");
    property p_gate; !MBOX1_IRQ_ENABLE && !MBOX1_IRQ_PENDING
        |=> !MBOX1_IRQ_PENDING;
    endproperty
    a_gate: assert property (p_gate) else $error("disabled set");
    // The image must mirror the loose flag ports bit for bit.
    property p_img; CTRL_STATUS == {MBOX3_IRQ_ENABLE, MBOX2_IRQ_ENABLE,
        MBOX1_IRQ_ENABLE, MBOX0_IRQ_ENABLE, MBOX3_IRQ_PENDING,
        MBOX2_IRQ_PENDING, MBOX1_IRQ_PENDING, MBOX0_IRQ_PENDING};
    endproperty
    a_img: assert property (p_img) else $error("image bad");
    property p_irq; IRQ == |(CTRL_STATUS[3:0] & CTRL_STATUS[7:4]); endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_clr; STAT_CLR && STAT_CLR_DATA[0] && !HOST_MBOX_WR[0]
        |=> !MBOX0_IRQ_PENDING; endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_hold; MBOX2_IRQ_PENDING && !(STAT_CLR && STAT_CLR_DATA[2])
        |=> MBOX2_IRQ_PENDING; endproperty
    a_hold: assert property (p_hold) else $error("pending lost");
    property p_ctrl; CTRL_WR |=> CTRL_STATUS[7:4] == $past(CTRL_WDATA[7:4]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("enable write");
    // Reset itself is checked, so this one is never disabled.
    property p_rst; disable iff (1'b0) !RST_N |=> CTRL_STATUS == MIF_IMG_RST
        && !IRQ; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    c_irq: cover property (IRQ);
    c_clr: cover property (STAT_CLR && IRQ);
    c_en3: cover property (CTRL_WR && CTRL_WDATA[7]);
endmodule // mif_properties

// ---- testbench/mif_host.sv ----
`timescale 1ns/10ps
// ============================================================
// Host side: writes mailboxes as one-cycle strobes.
// ============================================================
module mif_host (
    // Clock.
    input  wire logic clk,
    // Host write strobes toward the block.
    output logic [3:0] host_wr
);
    initial host_wr = 4'h0;
    // Strobe launched just after an edge so it is taken at the next one.
    task write(input logic [3:0] m);
        @(posedge clk);
        #1 host_wr = m;
        @(posedge clk);
        #1 host_wr = 4'h0;
    endtask
endmodule // mif_host

// ---- testbench/test_mailbox_interrupt_flags.sv ----
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the mailbox interrupt flags.
// ============================================================
module test_mailbox_interrupt_flags;
    import mif_pkg::*;
    logic       MCLK = 1'b0, RST_N = 1'b0, CTRL_WR = 1'b0, STAT_CLR = 1'b0;
    logic [7:0] CTRL_WDATA = 8'h00, STAT_CLR_DATA = 8'h00, e;
    logic [3:0] host_wr;
    logic       cnt_clr = 1'b0;
    logic [1:0] cnt_sel = 2'h0;
    wire  [7:0] st;
    wire        irq;
    wire  [3:0] ovr;
    wire  [7:0] cnt;
    int         error_cnt = 0, n_tests = 0, cycles = 0;

    mif_host host (.clk(MCLK), .host_wr(host_wr));
    // Every control input is driven so that the counters are tested too.
    mif_top DUT (.MCLK(MCLK), .RST_N(RST_N), .CTRL_WR(CTRL_WR),
        .CTRL_WDATA(CTRL_WDATA), .STAT_CLR(STAT_CLR),
        .STAT_CLR_DATA(STAT_CLR_DATA), .HOST_MBOX_WR(host_wr),
        .CNT_CLR(cnt_clr), .CNT_SEL(cnt_sel), .MBOX0_IRQ_ENABLE(),
        .MBOX1_IRQ_ENABLE(), .MBOX2_IRQ_ENABLE(), .MBOX3_IRQ_ENABLE(),
        .MBOX0_IRQ_PENDING(), .MBOX1_IRQ_PENDING(), .MBOX2_IRQ_PENDING(),
        .MBOX3_IRQ_PENDING(), .CTRL_STATUS(st), .OVERRUN(ovr), .CNT_VALUE(cnt),
        .IRQ(irq));

    // A 125 MHz clock.
    initial forever #4 MCLK = ~MCLK;

    // Control word write, taken at the second edge.
    task pulse_ctrl(input logic [7:0] d);
        @(posedge MCLK);
        #1 CTRL_WR = 1'b1;
        CTRL_WDATA = d;
        @(posedge MCLK);
        #1 CTRL_WR = 1'b0;
    endtask

    // Write-one-to-clear word, taken at the second edge.
    task pulse_clr(input logic [7:0] d);
        @(posedge MCLK);
        #1 STAT_CLR = 1'b1;
        STAT_CLR_DATA = d;
        @(posedge MCLK);
        #1 STAT_CLR = 1'b0;
    endtask

    // Counter clear pulse, taken at the second edge.
    task pulse_cnt_clr;
        @(posedge MCLK);
        #1 cnt_clr = 1'b1;
        @(posedge MCLK);
        #1 cnt_clr = 1'b0;
    endtask

    // Counter select; the chosen count shows after the next edge.
    task sel_cnt(input logic [1:0] s);
        @(posedge MCLK);
        #1 cnt_sel = s;
        @(posedge MCLK);
        #1;
    endtask

    // Compare the overrun flags.
    task cmp_ovr(input logic [3:0] o);
        n_tests++;
        if (ovr !== o) begin
            error_cnt++;
            $display("BAD %0t overrun %h", $time, ovr);
        end
    endtask

    // Compare the selected accepted-write count.
    task cmp_cnt(input logic [7:0] c);
        n_tests++;
        if (cnt !== c) begin
            error_cnt++;
            $display("BAD %0t count %h", $time, cnt);
        end
    endtask

    // Compare the status image and the interrupt line.
    task cmp_stat(input logic [7:0] s, input logic q);
        n_tests++;
        if (st !== s || irq !== q) begin
            error_cnt++;
            $display("BAD %0t status %h irq %b", $time, st, irq);
        end
    endtask

    task final_report;
        $display("Tests %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // A hang is cut short well beyond the 65 or so cycles needed.
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            final_report;
        end
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge MCLK);
        #1 RST_N = 1'b1;
        cmp_stat(8'h00, 1'b0);
        host.write(4'hF);
        cmp_stat(8'h00, 1'b0);
        // One mailbox enabled at a time; the host writes all four.
        for (int i = 0; i < 4; i++) begin
            e = 8'h10 << i;
            pulse_ctrl(e);
            host.write(4'hF);
            cmp_stat(e | (8'h01 << i), 1'b1);
            pulse_clr(~(8'h01 << i));
            cmp_stat(e | (8'h01 << i), 1'b1);
            pulse_clr(8'h01 << i);
            cmp_stat(e, 1'b0);
        end
        // Disabling while pending drops the line but keeps the flag.
        pulse_ctrl(8'h20);
        host.write(4'h2);
        pulse_ctrl(8'h00);
        cmp_stat(8'h02, 1'b0);
        pulse_clr(8'h02);
        pulse_ctrl(8'hF0);
        host.write(4'h5);
        cmp_stat(8'hF5, 1'b1);
        // Disabled host writes must not reach the counters.
        cmp_cnt(8'h02);
        sel_cnt(2'h1);
        cmp_cnt(8'h02);
        sel_cnt(2'h3);
        cmp_cnt(8'h01);
        // A second write while still pending marks an overrun.
        host.write(4'h1);
        cmp_ovr(4'h1);
        // Set and clear in one cycle: the set wins, no overrun.
        fork
            host.write(4'h4);
            pulse_clr(8'h04);
        join
        cmp_stat(8'hF5, 1'b1);
        cmp_ovr(4'h1);
        pulse_clr(8'h15);
        cmp_stat(8'hF0, 1'b0);
        cmp_ovr(4'h0);
        // Counter clear, then a clear and an accepted write together.
        pulse_cnt_clr;
        cmp_cnt(8'h00);
        fork
            host.write(4'h8);
            pulse_cnt_clr;
        join
        cmp_cnt(8'h01);
        cmp_stat(8'hF8, 1'b1);
        final_report;
    end
endmodule // test_mailbox_interrupt_flags

bind mif_top mif_properties u_prop (.MCLK(MCLK), .RST_N(RST_N),
    .CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA), .STAT_CLR(STAT_CLR),
    .STAT_CLR_DATA(STAT_CLR_DATA), .HOST_MBOX_WR(HOST_MBOX_WR),
    .MBOX0_IRQ_ENABLE(MBOX0_IRQ_ENABLE), .MBOX1_IRQ_ENABLE(MBOX1_IRQ_ENABLE),
    .MBOX2_IRQ_ENABLE(MBOX2_IRQ_ENABLE), .MBOX3_IRQ_ENABLE(MBOX3_IRQ_ENABLE),
    .MBOX0_IRQ_PENDING(MBOX0_IRQ_PENDING),
    .MBOX1_IRQ_PENDING(MBOX1_IRQ_PENDING),
    .MBOX2_IRQ_PENDING(MBOX2_IRQ_PENDING),
    .MBOX3_IRQ_PENDING(MBOX3_IRQ_PENDING),
    .CTRL_STATUS(CTRL_STATUS), .IRQ(IRQ));
